//--- deac_pkg.sv
package deac_pkg;

	// Register addresses on the core's special function register bus
	localparam logic [11:0] OFF_CONTROL = 12'h0_FA6;
	localparam logic [11:0] OFF_UNLOCK_KEY = 12'h0_FA7;
	localparam logic [11:0] OFF_DATA = 12'h0_FA8;
	localparam logic [11:0] OFF_ADDR_LOW = 12'h0_FA9;
	localparam logic [11:0] OFF_ADDR_HIGH = 12'h0_FAA;
	localparam logic [11:0] OFF_FLAG2 = 12'h0_FA1;

	// Control register fields
	localparam int BIT_READ_START = 0;
	localparam int BIT_WRITE_START = 1;
	localparam int BIT_WRITE_PERMIT = 2;
	localparam int BIT_WRITE_ABORT = 3;
	localparam int BIT_ROW_ERASE = 4;
	localparam int BIT_CONFIG_SEL = 6;
	localparam int BIT_PROGRAM_SEL = 7;

	// Flag register field
	localparam int BIT_WRITE_DONE = 4;

	// Array geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int DEPTH = 1024;
	localparam int ADDR_HIGH_W = 2;

	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic RESET_BIT = 1'b0;

	// Unlock key sequence and erased cell value
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// Self-timed write duration
	localparam int CLK_PERIOD_NS = 10;
	localparam int WRITE_TIME_NS = 4000000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 24;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} deac_key_type;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_ERASE,
		WR_PROGRAM
	} deac_write_type;

endpackage

//--- deac_mem.sv
`timescale 1ns/1ps
module deac_mem
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [deac_pkg::ADDR_W-1:0] addr,
	input wire logic [deac_pkg::DATA_W-1:0] wdata,
	output logic [deac_pkg::DATA_W-1:0] rdata
);
	logic [deac_pkg::DATA_W-1:0] cells [deac_pkg::DEPTH];

	// No reset: array contents are nonvolatile
	always_ff @(posedge clk)
	begin
		if (wr_en)
			cells[addr] <= wdata;
		rdata <= cells[addr];
	end
endmodule

//--- deac_ctrl.sv
`timescale 1ns/1ps
// How it works
// - 1024-byte array, 10-bit address up to 3FFh.
// - High address holds two bits; rest read zero.
// - Write erases first; internal timer sets duration.
// - Unlock key port stores nothing, reads zero.
// - Software only sets start bits; hardware clears.
// - Write permit bit 2 gates writes; resets cleared.
// - Warm reset during write sets abort, zeroes regs.
// - Abort keeps space selects and row erase.
// - Write done flag set by hardware, software clears.
// - Bit 7 selects program flash over data array.
// - Bit 6 selects configuration space.
// - Bit 4 makes next program or config write erase a row.
// - Write start launches timed cycle, reads busy.
// - Read start reads one cycle; blocked in program space.
// - Data register is eight bits, both directions.
// - Write needs 55h, AAh, then write start.
// - Permit set beforehand; all but flag register and unlock key port frozen while busy.
// - Read byte ready next cycle, held till changed.
module deac_ctrl
#(
	parameter int WRITE_CYCLES = deac_pkg::WRITE_CYCLES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic master_clear_reset,
	input wire logic watchdog_timeout,
	input wire logic [11:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [7:0] config_read_byte,
	output logic flash_op_start,
	output logic flash_op_row_erase,
	output logic flash_op_config,
	output logic [7:0] flash_op_data,
	output logic write_busy
);
	localparam logic [deac_pkg::TIMER_W-1:0] TIMER_LAST =
		deac_pkg::TIMER_W'(WRITE_CYCLES - 1);

	// Address match on the SFR bus
	function automatic logic sfr_hit(input logic [11:0] a,
		input logic [11:0] off);
		sfr_hit = (a == off);
	endfunction

	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic [7:0] addr_low_reg;
	logic [7:0] addr_low_next;
	logic [1:0] addr_high_reg;
	logic [1:0] addr_high_next;
	logic program_sel_reg;
	logic config_sel_reg;
	logic row_erase_reg;
	logic abort_reg;
	logic permit_reg;
	logic write_start_reg;
	logic read_start_reg;
	logic done_reg;
	logic target_data_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [deac_pkg::TIMER_W-1:0] timer_reg;
	deac_pkg::deac_key_type key_reg;
	deac_pkg::deac_key_type key_next;
	deac_pkg::deac_write_type wr_state_reg;
	deac_pkg::deac_write_type wr_state_next;

	wire warm_reset = master_clear_reset | watchdog_timeout;
	wire busy = (wr_state_reg != deac_pkg::WR_IDLE);
	wire [deac_pkg::ADDR_W-1:0] array_addr = {addr_high_reg, addr_low_reg};

	wire hit_ctrl = sfr_hit(sfr_addr, deac_pkg::OFF_CONTROL);
	wire hit_key = sfr_hit(sfr_addr, deac_pkg::OFF_UNLOCK_KEY);
	wire hit_data = sfr_hit(sfr_addr, deac_pkg::OFF_DATA);
	wire hit_low = sfr_hit(sfr_addr, deac_pkg::OFF_ADDR_LOW);
	wire hit_high = sfr_hit(sfr_addr, deac_pkg::OFF_ADDR_HIGH);
	wire hit_flag = sfr_hit(sfr_addr, deac_pkg::OFF_FLAG2);

	// Frozen registers ignore writes during a self-timed cycle
	wire reg_wr = sfr_wr & ~busy & ~warm_reset;
	wire ctrl_wr = reg_wr & hit_ctrl;
	wire key_wr = sfr_wr & hit_key & ~warm_reset;

	// Start requests decoded from the written control byte
	wire ask_read = ctrl_wr & sfr_wdata[deac_pkg::BIT_READ_START];
	wire ask_write = ctrl_wr & sfr_wdata[deac_pkg::BIT_WRITE_START];
	wire new_psel = sfr_wdata[deac_pkg::BIT_PROGRAM_SEL];
	wire new_cfg = sfr_wdata[deac_pkg::BIT_CONFIG_SEL];

	// Read is refused when program space is selected
	wire read_go = ask_read & ~new_psel;
	// Permit must already be set; the key must be armed
	wire write_go = ask_write & permit_reg & (key_reg == deac_pkg::KEY_ARMED);
	wire target_data = ~new_psel & ~new_cfg;

	wire timer_end = (timer_reg == TIMER_LAST);
	wire write_end = (wr_state_reg == deac_pkg::WR_PROGRAM) & timer_end;

	wire mem_we = ((wr_state_reg == deac_pkg::WR_ERASE) |
		write_end) & target_data_reg & ~warm_reset;
	// Erase cell to blank first, program new byte at the end
	wire [7:0] mem_wdata = (wr_state_reg == deac_pkg::WR_ERASE) ?
		deac_pkg::ERASED_BYTE : data_reg;
	wire [7:0] mem_rdata;

	deac_mem deac_mem_i
	(
		.clk(clk),
		.wr_en(mem_we),
		.addr(array_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// Readback of the control register; bit 5 unimplemented
	wire [7:0] ctrl_view = {program_sel_reg, config_sel_reg, 1'b0,
		row_erase_reg, abort_reg, permit_reg, write_start_reg,
		read_start_reg};

	// Unlock sequence tracker
	always_comb
	begin
		key_next = key_reg;
		if (warm_reset)
			key_next = deac_pkg::KEY_IDLE;
		else if (key_wr)
		begin
			if (sfr_wdata == deac_pkg::KEY_FIRST)
				key_next = deac_pkg::KEY_GOT_FIRST;
			else if (sfr_wdata == deac_pkg::KEY_SECOND &&
				key_reg == deac_pkg::KEY_GOT_FIRST)
				key_next = deac_pkg::KEY_ARMED;
			else
				key_next = deac_pkg::KEY_IDLE;
		end
		else if (sfr_wr)
			key_next = deac_pkg::KEY_IDLE;
	end

	// Self-timed write sequencer
	always_comb
	begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			deac_pkg::WR_IDLE:
				if (write_go)
					wr_state_next = deac_pkg::WR_ERASE;
			deac_pkg::WR_ERASE:
				wr_state_next = deac_pkg::WR_PROGRAM;
			deac_pkg::WR_PROGRAM:
				if (timer_end)
					wr_state_next = deac_pkg::WR_IDLE;
			default:
				wr_state_next = deac_pkg::WR_IDLE;
		endcase
		if (warm_reset)
			wr_state_next = deac_pkg::WR_IDLE;
	end

	// Data register: software write, else loaded by a read
	always_comb
	begin
		data_next = data_reg;
		if (warm_reset)
			data_next = deac_pkg::RESET_BYTE;
		else if (reg_wr && hit_data)
			data_next = sfr_wdata;
		else if (read_start_reg)
			data_next = target_data_reg ? mem_rdata :
				config_read_byte;
	end

	// Address registers
	always_comb
	begin
		addr_low_next = addr_low_reg;
		addr_high_next = addr_high_reg;
		if (warm_reset)
		begin
			addr_low_next = deac_pkg::RESET_BYTE;
			addr_high_next = deac_pkg::ADDR_HIGH_W'(deac_pkg::RESET_BYTE);
		end
		else
		begin
			if (reg_wr && hit_low)
				addr_low_next = sfr_wdata;
			if (reg_wr && hit_high)
				addr_high_next = sfr_wdata[deac_pkg::ADDR_HIGH_W-1:0];
		end
	end

	// Bus read mux; key port and unmapped addresses read zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (hit_ctrl)
			rdata_next = ctrl_view;
		else if (hit_key)
			rdata_next = 8'h00;
		else if (hit_data)
			rdata_next = data_reg;
		else if (hit_low)
			rdata_next = addr_low_reg;
		else if (hit_high)
			rdata_next = {6'h00, addr_high_reg};
		else if (hit_flag)
			rdata_next = 8'(done_reg) << deac_pkg::BIT_WRITE_DONE;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			data_reg <= deac_pkg::RESET_BYTE;
			addr_low_reg <= deac_pkg::RESET_BYTE;
			addr_high_reg <= '0;
			key_reg <= deac_pkg::KEY_IDLE;
			wr_state_reg <= deac_pkg::WR_IDLE;
			rdata_reg <= deac_pkg::RESET_BYTE;
		end
		else
		begin
			data_reg <= data_next;
			addr_low_reg <= addr_low_next;
			addr_high_reg <= addr_high_next;
			key_reg <= key_next;
			wr_state_reg <= wr_state_next;
			rdata_reg <= sfr_rd ? rdata_next : rdata_reg;
		end
	end

	// Cycle timer runs only in the program phase
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			timer_reg <= '0;
		else if (wr_state_reg == deac_pkg::WR_PROGRAM && !timer_end)
			timer_reg <= timer_reg + 1'b1;
		else
			timer_reg <= '0;
	end

	// Space selects and row erase; kept across a warm reset
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			program_sel_reg <= deac_pkg::RESET_BIT;
			config_sel_reg <= deac_pkg::RESET_BIT;
			row_erase_reg <= deac_pkg::RESET_BIT;
		end
		else if (ctrl_wr)
		begin
			program_sel_reg <= new_psel;
			config_sel_reg <= new_cfg;
			row_erase_reg <= sfr_wdata[deac_pkg::BIT_ROW_ERASE];
		end
		// Warm reset keeps row erase so the aborted op can be traced
		else if (write_end && row_erase_reg && !target_data_reg &&
			!warm_reset)
			row_erase_reg <= deac_pkg::RESET_BIT;
	end

	// Abort flag and write permit
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			abort_reg <= deac_pkg::RESET_BIT;
			permit_reg <= deac_pkg::RESET_BIT;
		end
		else if (warm_reset)
		begin
			abort_reg <= busy | abort_reg;
			permit_reg <= deac_pkg::RESET_BIT;
		end
		else if (ctrl_wr)
		begin
			abort_reg <= sfr_wdata[deac_pkg::BIT_WRITE_ABORT];
			permit_reg <= sfr_wdata[deac_pkg::BIT_WRITE_PERMIT];
		end
	end

	// Start bits: software sets, hardware clears at completion
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			write_start_reg <= deac_pkg::RESET_BIT;
			read_start_reg <= deac_pkg::RESET_BIT;
			target_data_reg <= deac_pkg::RESET_BIT;
		end
		else if (warm_reset)
		begin
			write_start_reg <= deac_pkg::RESET_BIT;
			read_start_reg <= deac_pkg::RESET_BIT;
		end
		else
		begin
			if (write_go)
				write_start_reg <= 1'b1;
			else if (write_end)
				write_start_reg <= deac_pkg::RESET_BIT;
			// One-cycle read, cleared the cycle after it was set
			read_start_reg <= read_go;
			if (write_go || read_go)
				target_data_reg <= target_data;
		end
	end

	// Done flag: set wins over a clearing write in the same cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			done_reg <= deac_pkg::RESET_BIT;
		else if (write_end && !warm_reset)
			done_reg <= 1'b1;
		else if (sfr_wr && hit_flag && !warm_reset &&
			!sfr_wdata[deac_pkg::BIT_WRITE_DONE])
			done_reg <= deac_pkg::RESET_BIT;
	end

	// Program or configuration space ops handed to the flash unit
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			flash_op_start <= 1'b0;
		else
			flash_op_start <= write_go & (new_psel | new_cfg);
	end

	assign sfr_rdata = rdata_reg;
	assign flash_op_row_erase = row_erase_reg;
	assign flash_op_config = config_sel_reg;
	assign flash_op_data = data_reg;
	assign write_busy = write_start_reg;
endmodule

//--- deac_ctrl_props.sv
`timescale 1ns/1ps
module deac_ctrl_props
#(
	parameter int WRITE_CYCLES = deac_pkg::WRITE_CYCLES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic master_clear_reset,
	input wire logic watchdog_timeout,
	input wire logic [11:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic [7:0] flash_op_data,
	input wire logic flash_op_row_erase,
	input wire logic flash_op_config,
	input wire logic flash_op_start,
	input wire logic write_busy
);
	logic [deac_pkg::TIMER_W-1:0] busy_len;
	// Counts busy cycles so the full write length can be checked
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			busy_len <= '0;
		else if (write_busy)
			busy_len <= busy_len + 1'b1;
		else
			busy_len <= '0;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wire warm = master_clear_reset || watchdog_timeout;
	wire ctrl_wr = sfr_wr && sfr_addr == deac_pkg::OFF_CONTROL;
	wire data_wr = sfr_wr && sfr_addr == deac_pkg::OFF_DATA;
	// Minimum run assumes WRITE_CYCLES of at least 7
	sequence busy_hold;
		write_busy [*8];
	endsequence
	sequence warm_soon;
		##[0:7] warm;
	endsequence
	AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	AST_KEY_READ_ZERO: assert property (sfr_rd && sfr_addr ==
		deac_pkg::OFF_UNLOCK_KEY |=> sfr_rdata == 8'h00)
		else $error("key port read not zero");
	AST_READ_DATA: assert property (sfr_rd && sfr_addr ==
		deac_pkg::OFF_DATA |=> sfr_rdata == $past(flash_op_data))
		else $error("data read mismatch");
	AST_START_CAUSE: assert property ($rose(write_busy) |->
		$past(ctrl_wr && sfr_wdata[1] && !warm))
		else $error("write began without a control write");
	AST_BUSY_MIN: assert property ($rose(write_busy) |->
		busy_hold or warm_soon)
		else $error("write ended early");
	AST_BUSY_ENDS: assert property ($rose(write_busy) |->
		##[1:1000] !write_busy)
		else $error("write never ended");
	AST_WARM_STOPS: assert property (warm |=>
		!write_busy && flash_op_data == 8'h00)
		else $error("warm reset left write or data");
	AST_WARM_KEEPS: assert property (warm |=>
		$stable(flash_op_row_erase) && $stable(flash_op_config))
		else $error("warm reset changed select bits");
	AST_DATA_FROZEN: assert property (write_busy && data_wr && !warm
		|=> $stable(flash_op_data))
		else $error("data changed during write");
	AST_DATA_LOAD: assert property (data_wr && !write_busy && !warm
		|=> flash_op_data == $past(sfr_wdata))
		else $error("data write not taken");
	AST_BUSY_LEN: assert property ($fell(write_busy) && !$past(warm)
		|-> busy_len == WRITE_CYCLES + 1)
		else $error("write length wrong");
	AST_FLASH_PULSE: assert property (flash_op_start |->
		$rose(write_busy) ##1 !flash_op_start)
		else $error("flash start not a single pulse");
endmodule
bind deac_ctrl deac_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) deac_ctrl_props_i
(
	.clk, .resetn, .master_clear_reset, .watchdog_timeout, .sfr_addr,
	.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .flash_op_data,
	.flash_op_row_erase, .flash_op_config, .flash_op_start, .write_busy
);

//--- deac_ctrl_bench.sv
`timescale 1ns/1ps
module deac_ctrl_bench;
	typedef struct packed {
		logic [11:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} deac_row_type;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic master_clear_reset = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic [11:0] sfr_addr = 12'h000;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [7:0] config_read_byte = 8'h5E;
	logic [7:0] flash_op_data;
	logic write_busy;
	logic flash_op_start;
	logic flash_op_row_erase;
	logic flash_op_config;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	deac_row_type rows [9];
	always #5 clk = ~clk;
	deac_ctrl #(.WRITE_CYCLES(8)) deac_ctrl_i
	(
		.clk, .resetn, .master_clear_reset, .watchdog_timeout, .sfr_addr,
		.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .config_read_byte,
		.flash_op_start, .flash_op_row_erase, .flash_op_config,
		.flash_op_data, .write_busy
	);
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Strobe spacing of two cycles keeps each drive in its own time step
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	task automatic read_check(input logic [11:0] a, input logic [7:0] e);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		check8(sfr_rdata, e);
	endtask
	task automatic unlock();
		wr(deac_pkg::OFF_UNLOCK_KEY, deac_pkg::KEY_FIRST);
		wr(deac_pkg::OFF_UNLOCK_KEY, deac_pkg::KEY_SECOND);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			final_report();
		end
	end
	initial
	begin
		rows = '{'{deac_pkg::OFF_ADDR_LOW, 8'hA5, 8'hA5},
			'{deac_pkg::OFF_ADDR_HIGH, 8'hFF, 8'h03},
			'{deac_pkg::OFF_DATA, 8'h3C, 8'h3C},
			'{deac_pkg::OFF_UNLOCK_KEY, 8'h55, 8'h00},
			'{deac_pkg::OFF_CONTROL, 8'hE4, 8'hC4},
			'{deac_pkg::OFF_CONTROL, 8'h81, 8'h80},
			'{deac_pkg::OFF_CONTROL, 8'h02, 8'h00},
			'{12'h0_F00, 8'hFF, 8'h00},
			'{deac_pkg::OFF_FLAG2, 8'h00, 8'h00}};
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		read_check(deac_pkg::OFF_CONTROL, 8'h00);
		read_check(deac_pkg::OFF_ADDR_HIGH, 8'h00);
		check8({5'h00, flash_op_start, flash_op_row_erase,
			flash_op_config}, 8'h00);
		check8(flash_op_data, 8'h00);
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			read_check(rows[i].a, rows[i].e);
		end
		wr(deac_pkg::OFF_CONTROL, 8'h41);
		check8({7'h00, flash_op_config}, 8'h01);
		read_check(deac_pkg::OFF_DATA, 8'h5E);
		$display("table test done");
		wr(deac_pkg::OFF_ADDR_HIGH, 8'h03);
		wr(deac_pkg::OFF_ADDR_LOW, 8'hFF);
		wr(deac_pkg::OFF_DATA, 8'h5A);
		check8(flash_op_data, 8'h5A);
		wr(deac_pkg::OFF_CONTROL, 8'h04);
		unlock();
		wr(deac_pkg::OFF_CONTROL, 8'h06);
		read_check(deac_pkg::OFF_CONTROL, 8'h06);
		wr(deac_pkg::OFF_DATA, 8'h00);
		read_check(deac_pkg::OFF_DATA, 8'h5A);
		for (int i = 0; i < 50 && write_busy !== 1'b0; i++)
			@(negedge clk);
		read_check(deac_pkg::OFF_CONTROL, 8'h04);
		read_check(deac_pkg::OFF_FLAG2, 8'h10);
		wr(deac_pkg::OFF_FLAG2, 8'h00);
		read_check(deac_pkg::OFF_FLAG2, 8'h00);
		wr(deac_pkg::OFF_DATA, 8'h00);
		wr(deac_pkg::OFF_CONTROL, 8'h05);
		read_check(deac_pkg::OFF_DATA, 8'h5A);
		read_check(deac_pkg::OFF_CONTROL, 8'h04);
		$display("write test done");
		wr(deac_pkg::OFF_UNLOCK_KEY, 8'h55);
		wr(deac_pkg::OFF_DATA, 8'h11);
		wr(deac_pkg::OFF_UNLOCK_KEY, 8'hAA);
		wr(deac_pkg::OFF_CONTROL, 8'h06);
		check8({7'h00, write_busy}, 8'h00);
		wr(deac_pkg::OFF_CONTROL, 8'h00);
		unlock();
		wr(deac_pkg::OFF_CONTROL, 8'h06);
		check8({7'h00, write_busy}, 8'h00);
		$display("refusal test done");
		wr(deac_pkg::OFF_CONTROL, 8'h94);
		check8({7'h00, flash_op_row_erase}, 8'h01);
		unlock();
		wr(deac_pkg::OFF_CONTROL, 8'h96);
		check8({6'h00, flash_op_start, write_busy}, 8'h03);
		@(negedge clk);
		check8({7'h00, flash_op_start}, 8'h00);
		for (int i = 0; i < 50 && write_busy !== 1'b0; i++)
			@(negedge clk);
		check8({7'h00, flash_op_row_erase}, 8'h00);
		read_check(deac_pkg::OFF_CONTROL, 8'h84);
		$display("program test done");
		for (int s = 0; s < 2; s++)
		begin
			wr(deac_pkg::OFF_ADDR_LOW, 8'h10);
			wr(deac_pkg::OFF_DATA, 8'h77);
			wr(deac_pkg::OFF_CONTROL, 8'h14);
			unlock();
			wr(deac_pkg::OFF_CONTROL, 8'h16);
			@(negedge clk);
			master_clear_reset = (s == 0);
			watchdog_timeout = (s == 1);
			@(negedge clk);
			master_clear_reset = 1'b0;
			watchdog_timeout = 1'b0;
			read_check(deac_pkg::OFF_CONTROL, 8'h18);
			read_check(deac_pkg::OFF_DATA, 8'h00);
			read_check(deac_pkg::OFF_ADDR_LOW, 8'h00);
			check8({7'h00, flash_op_row_erase}, 8'h01);
			check8(flash_op_data, 8'h00);
		end
		wr(deac_pkg::OFF_ADDR_LOW, 8'h10);
		wr(deac_pkg::OFF_CONTROL, 8'h01);
		read_check(deac_pkg::OFF_DATA, 8'hFF);
		$display("abort test done");
		final_report();
	end
endmodule
